// ---- logic/sosc_standby_ctrl.sv ----
`timescale 1ns/1ps
`include "sosc_defines.svh"

module sosc_standby_ctrl
    import sosc_pkg::*;
#(
    parameter int CNT_W = 17
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // cpu instruction strobes and interrupt state
    input wire logic haltExec,
    input wire logic stopExec,
    input wire logic intPending,
    input wire logic intAckEnable,
    input wire logic cpuOnCrystal,
    // oscillator state before standby and crystal status
    input wire sosc_osc_t oscBefore,
    input wire logic crystalTick,
    input wire logic mainOscStopWr,
    // register bus
    input wire sosc_bus_req_t busReq,
    output logic [7:0] busRdata,
    // standby outputs
    output logic cpuClkEnable,
    output logic portHold,
    output logic vectorTake,
    output sosc_osc_t oscRun,
    output logic [2:0] stateCode
);

    // standby sequencing state
    sosc_state_t state_reg;
    sosc_state_t state_next;
    logic [3:0] wait_reg;
    logic [3:0] wait_next;
    logic vec_reg;
    logic vec_next;

    // stabilization counter
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;

    // status flags, bit 4 is the shortest threshold
    logic [4:0] status_reg;
    logic [4:0] status_next;

    // wait select field
    logic [2:0] select_reg;
    logic [2:0] select_next;

    // registered read data
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    // threshold and selection decodes
    logic [4:0] expReached;
    logic [4:0] selMask;
    logic [4:0] selEdge;
    logic [4:0] flagSet;
    logic selLegal;
    logic stabDone;

    // counter control
    logic cntClear;
    logic cntStep;

    // sequencing helpers
    logic inRun;
    logic inHalt;
    logic inStop;
    logic [3:0] wakeWait;

    // register bus decodes
    logic selWrite;
    logic statusRead;
    logic selectRead;

    // exponent per status bit; index 0 is the longest wait
    localparam int EXPS [5] = '{`SOSC_EXP_2E16, `SOSC_EXP_2E15, `SOSC_EXP_2E14,
                                `SOSC_EXP_2E13, `SOSC_EXP_2E11};

    // threshold compare and select gating, one slice per flag
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_thr
            // counter value 2^exp - 1 means 2^exp crystal cycles have passed
            assign expReached[gi] = (cnt_reg >= CNT_W'((1 << EXPS[gi]) - 1));
            // thresholds beyond the selected one are never flagged
            assign selMask[gi] = (32'(select_reg) >= 32'(5 - gi));
            // a flag sets once its threshold passed and stays set
            assign flagSet[gi] = expReached[gi] && selMask[gi];
        end
    endgenerate

    // lowest set bit of the mask is the selected threshold itself
    assign selEdge = selMask & ~(selMask << 1);

    // legal select codes are 1..5
    always_comb begin
        case (select_reg)
            3'd1, 3'd2, 3'd3, 3'd4, 3'd5: selLegal = 1'b1;
            default: selLegal = 1'b0;
        endcase
    end

    // prohibited codes act like the longest wait so the cpu is never released early
    always_comb begin
        if (selLegal) begin
            stabDone = |(expReached & selEdge);
        end else begin
            stabDone = expReached[0];
        end
    end

    // state decodes shared by several groups
    assign inRun = (state_reg == SOSC_RUN);
    assign inHalt = (state_reg == SOSC_HALT);
    assign inStop = (state_reg == SOSC_STOP);

    // wake wait depends on whether a vectored service follows
    assign wakeWait = intAckEnable ? `SOSC_HALT_WAIT_VEC : `SOSC_HALT_WAIT_NOVEC;

    // standby sequencing
    always_comb begin
        state_next = state_reg;
        wait_next = wait_reg;
        vec_next = 1'b0;
        case (state_reg)
            SOSC_RUN: begin
                if (stopExec) begin
                    // pending interrupt turns stop into halt-like wake after the wait
                    state_next = intPending ? SOSC_STAB : SOSC_STOP;
                end else if (haltExec) begin
                    state_next = intPending ? SOSC_WAKE : SOSC_HALT;
                    wait_next = wakeWait;
                end
            end
            SOSC_HALT: begin
                if (intPending) begin
                    state_next = SOSC_WAKE;
                    wait_next = wakeWait;
                end
            end
            SOSC_STOP: begin
                if (intPending) begin
                    state_next = SOSC_STAB;
                end
            end
            SOSC_STAB: begin
                // fast-osc cpu skips the stabilization wait, software polls the status itself
                if (!cpuOnCrystal || stabDone) begin
                    state_next = SOSC_WAKE;
                    wait_next = wakeWait;
                end
            end
            SOSC_WAKE: begin
                if (wait_reg == 4'd0) begin
                    state_next = SOSC_RUN;
                    vec_next = intAckEnable;
                end else begin
                    wait_next = wait_reg - 4'd1;
                end
            end
            default: begin
                state_next = SOSC_RUN;
            end
        endcase
    end

    // sequencing registers; reset leaves any standby state at once
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= SOSC_RUN;
            wait_reg <= 4'd0;
            vec_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            wait_reg <= wait_next;
            vec_reg <= vec_next;
        end
    end

    // a stop instruction or the oscillator stop bit restarts the count
    assign cntClear = stopExec || mainOscStopWr;
    // only real crystal cycles count, never while the crystal is stopped
    assign cntStep = crystalTick && !stabDone && !inStop;

    // stabilization counter, saturates at the selected threshold
    always_comb begin
        cnt_next = cnt_reg;
        if (cntClear) begin
            cnt_next = '0;
        end else if (cntStep) begin
            cnt_next = cnt_reg + CNT_W'(1);
        end
    end

    // counter register
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // status flags; the clear of a new count wins over a stale set
    always_comb begin
        status_next = status_reg;
        if (cntClear) begin
            status_next = 5'b0_0000;
        end else begin
            status_next = status_reg | flagSet;
        end
    end

    // status register
    always_ff @(posedge clk) begin
        if (reset) begin
            status_reg <= 5'(`SOSC_STATUS_RESET);
        end else begin
            status_reg <= status_next;
        end
    end

    // register bus decodes; writes to the status address are ignored
    assign selWrite = busReq.wr && (busReq.addr == `SOSC_ADDR_SELECT);
    assign statusRead = busReq.rd && (busReq.addr == `SOSC_ADDR_STATUS);
    assign selectRead = busReq.rd && (busReq.addr == `SOSC_ADDR_SELECT);

    // select register: whole-byte writes only, upper bits dropped
    always_comb begin
        select_next = select_reg;
        if (selWrite) begin
            select_next = busReq.wdata[2:0];
        end
    end

    // select register storage
    always_ff @(posedge clk) begin
        if (reset) begin
            select_reg <= 3'(`SOSC_SELECT_RESET);
        end else begin
            select_reg <= select_next;
        end
    end

    // read data, status is read-only, unmapped reads return zero
    always_comb begin
        rdata_next = 8'h00;
        if (statusRead) begin
            rdata_next = {3'b000, status_reg};
        end else if (selectRead) begin
            rdata_next = {5'b0_0000, select_reg};
        end
    end

    // read data register, valid the cycle after the request
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // bus and cpu outputs; cpu state and port latches are frozen by gating, not reloaded
    assign busRdata = rdata_reg;
    assign cpuClkEnable = inRun;
    assign portHold = !inRun;
    assign vectorTake = vec_reg;

    // oscillator controls; halt changes none, stop drops the two main ones
    assign oscRun.crystalRun = oscBefore.crystalRun && !inStop;
    assign oscRun.fastRun = oscBefore.fastRun && !inStop;
    assign oscRun.slowRun = oscBefore.slowRun;
    assign oscRun.subRun = oscBefore.subRun;

    // coarse state for the outside; stabilize and wake show all zero
    assign stateCode = {inStop, inHalt, inRun};

endmodule // sosc_standby_ctrl

// ---- logic/sosc_defines.svh ----
`ifndef SOSC_DEFINES_SVH
`define SOSC_DEFINES_SVH

`define SOSC_ADDR_STATUS 16'hFFA3
`define SOSC_ADDR_SELECT 16'hFFA4
`define SOSC_STATUS_RESET 8'h00
`define SOSC_SELECT_RESET 8'h05
`define SOSC_MAIN_OSC_STOP_CTL_BIT 7
`define SOSC_EXP_2E11 11
`define SOSC_EXP_2E13 13
`define SOSC_EXP_2E14 14
`define SOSC_EXP_2E15 15
`define SOSC_EXP_2E16 16
`define SOSC_HALT_WAIT_VEC 4'd11
`define SOSC_HALT_WAIT_NOVEC 4'd4

`endif

// ---- logic/sosc_pkg.sv ----
package sosc_pkg;
    // standby mode states
    typedef enum logic [4:0] {
        SOSC_RUN = 5'b0_0001,
        SOSC_HALT = 5'b0_0010,
        SOSC_STOP = 5'b0_0100,
        SOSC_STAB = 5'b0_1000,
        SOSC_WAKE = 5'b1_0000
    } sosc_state_t;

    // register bus request from the CPU
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } sosc_bus_req_t;

    // oscillator run controls
    typedef struct packed {
        logic crystalRun;
        logic fastRun;
        logic slowRun;
        logic subRun;
    } sosc_osc_t;
endpackage

// ---- verification/sosc_standby_props.sv ----
`timescale 1ns/1ps
module sosc_standby_props
    import sosc_pkg::*;
(
    // watched ports
    input wire logic clk,
    input wire logic reset,
    input wire logic haltExec,
    input wire logic stopExec,
    input wire logic intPending,
    input wire logic intAckEnable,
    input wire sosc_osc_t oscBefore,
    input wire sosc_bus_req_t busReq,
    input wire logic [7:0] busRdata,
    input wire logic cpuClkEnable,
    input wire logic portHold,
    input wire logic vectorTake,
    input wire sosc_osc_t oscRun,
    input wire logic [2:0] stateCode
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    property p_halt_gate; haltExec && cpuClkEnable |=> !cpuClkEnable; endproperty
    a_halt_gate: assert property (p_halt_gate) else $error("cpu clock kept");
    property p_halt_osc; stateCode[1] |-> oscRun == oscBefore; endproperty
    a_halt_osc: assert property (p_halt_osc) else $error("halt osc changed");
    property p_stop_osc; stateCode[2] |-> !oscRun.crystalRun && !oscRun.fastRun; endproperty
    a_stop_osc: assert property (p_stop_osc) else $error("stop osc running");
    property p_stop_enter; stopExec && cpuClkEnable && !intPending |=> stateCode[2]; endproperty
    a_stop_enter: assert property (p_stop_enter) else $error("stop not entered");
    property p_stop_wake; stateCode[2] && intPending |=> !stateCode[2]; endproperty
    a_stop_wake: assert property (p_stop_wake) else $error("stop not left");
    property p_sub_run; oscRun.subRun == oscBefore.subRun && oscRun.slowRun == oscBefore.slowRun; endproperty
    a_sub_run: assert property (p_sub_run) else $error("sub osc changed");
    property p_port_hold; !cpuClkEnable |-> portHold; endproperty
    a_port_hold: assert property (p_port_hold) else $error("ports not held");
    property p_unmapped; busReq.rd && busReq.addr != 16'hffa3 && busReq.addr != 16'hffa4 |=> busRdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read data");
    // halt exit must not come before the short wait
    property p_halt_wait; $rose(intPending) && stateCode[1] |-> !cpuClkEnable [*4] ##[1:12] cpuClkEnable; endproperty
    a_halt_wait: assert property (p_halt_wait) else $error("halt wait off");
    property p_vector; vectorTake |-> intAckEnable ##1 !vectorTake; endproperty
    a_vector: assert property (p_vector) else $error("bad vector pulse");
    c_stop: cover property (stateCode[2] && intPending);
    c_halt: cover property (stateCode[1] && intPending);
    c_vec: cover property (vectorTake);
endmodule // sosc_standby_props

bind sosc_standby_ctrl sosc_standby_props sosc_standby_props_i (.clk(clk), .reset(reset), .haltExec(haltExec),
    .stopExec(stopExec), .intPending(intPending), .intAckEnable(intAckEnable), .oscBefore(oscBefore),
    .busReq(busReq), .busRdata(busRdata), .cpuClkEnable(cpuClkEnable), .portHold(portHold),
    .vectorTake(vectorTake), .oscRun(oscRun), .stateCode(stateCode));

// ---- verification/sosc_cpu_model.sv ----
`timescale 1ns/1ps
module sosc_cpu_model
    import sosc_pkg::*;
(
    // clock and read data
    input wire logic clk,
    input wire logic [7:0] busRdata,
    // instruction strobes and bus
    output logic haltExec,
    output logic stopExec,
    output sosc_bus_req_t busReq
);
    initial begin
        haltExec = 1'b0;
        stopExec = 1'b0;
        busReq = '0;
    end
    // stop only issued on main clock, peripherals idle
    task automatic standby(input logic isStop);
        @(negedge clk);
        stopExec = isStop;
        haltExec = !isStop;
        @(negedge clk);
        stopExec = 1'b0;
        haltExec = 1'b0;
    endtask
    // whole-byte access, never during a wait
    task automatic access(input logic wr, input logic [15:0] addr, input logic [7:0] wdata, output logic [7:0] rdata);
        @(negedge clk);
        busReq = '{rd: !wr, wr: wr, addr: addr, wdata: wdata};
        @(negedge clk);
        rdata = busRdata;
        busReq = '0;
    endtask
endmodule // sosc_cpu_model

// ---- verification/sosc_standby_ctrl_test.sv ----
`timescale 1ns/1ps
module sosc_standby_ctrl_test
    import sosc_pkg::*;
;
    logic clk = 1'b0, reset = 1'b1, intPending = 1'b0, intAckEnable = 1'b0, cpuOnCrystal = 1'b1;
    logic crystalTick = 1'b1, mainOscStopWr = 1'b0, haltExec, stopExec, cpuClkEnable, portHold, vectorTake;
    logic vecSeen = 1'b0;
    logic [7:0] busRdata, rd;
    logic [2:0] stateCode;
    sosc_osc_t oscBefore = '0, oscRun;
    sosc_bus_req_t busReq;
    int error_cnt = 0, checks = 0, cyc = 0, n;
    int exps[5] = '{11, 13, 14, 15, 16};
    always #2.5 clk = ~clk;
    sosc_standby_ctrl sosc_standby_ctrl_i (.clk(clk), .reset(reset), .haltExec(haltExec), .stopExec(stopExec),
        .intPending(intPending), .intAckEnable(intAckEnable), .cpuOnCrystal(cpuOnCrystal), .oscBefore(oscBefore),
        .crystalTick(crystalTick), .mainOscStopWr(mainOscStopWr), .busReq(busReq), .busRdata(busRdata),
        .cpuClkEnable(cpuClkEnable), .portHold(portHold), .vectorTake(vectorTake), .oscRun(oscRun),
        .stateCode(stateCode));
    sosc_cpu_model sosc_cpu_model_i (.clk(clk), .busRdata(busRdata), .haltExec(haltExec), .stopExec(stopExec),
        .busReq(busReq));
    // flags stay gated by the select code
    function automatic logic [7:0] model(int sel, int ticks);
        model = 8'h00;
        for (int i = 0; i < 5; i++)
            if (i < sel && ticks >= (1 << exps[i])) model[4 - i] = 1'b1;
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // raise the wake request and count cycles until the cpu runs
    task automatic wake(output int k);
        k = 0;
        intPending = 1'b1;
        while (cpuClkEnable !== 1'b1 && k < 70000) begin
            @(negedge clk);
            k++;
        end
        intPending = 1'b0;
    endtask
    task automatic stop_run(input int sel, input logic xtal);
        cpuOnCrystal = xtal;
        oscBefore = sosc_osc_t'(4'($urandom));
        // select always programmed before the stop
        sosc_cpu_model_i.access(1'b1, 16'hffa4, 8'(sel), rd);
        sosc_cpu_model_i.standby(1'b1);
        repeat (5) @(negedge clk);
        wake(n);
        chk(xtal ? n >= (1 << exps[sel - 1]) : n < 40, 1'b1);
        sosc_cpu_model_i.access(1'b0, 16'hffa3, 8'h00, rd);
        chk(rd, model(sel, n + 2));
    endtask
    always @(negedge clk) if (vectorTake === 1'b1) vecSeen <= 1'b1;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            tally_and_finish;
        end
    end
    initial begin
        void'($urandom(32'hc2c3));
        repeat (20) @(negedge clk);
        reset = 1'b0;
        sosc_cpu_model_i.access(1'b0, 16'hffa3, 8'h00, rd);
        chk(rd, 8'h00);
        sosc_cpu_model_i.access(1'b0, 16'hffa4, 8'h00, rd);
        chk(rd, 8'h05);
        sosc_cpu_model_i.access(1'b1, 16'hffa3, 8'hff, rd);
        sosc_cpu_model_i.access(1'b0, 16'hffa3, 8'h00, rd);
        chk(rd, 8'h00);
        sosc_cpu_model_i.access(1'b0, 16'hffa5, 8'h00, rd);
        chk(rd, 8'h00);
        for (int c = 1; c < 6; c++) begin
            sosc_cpu_model_i.access(1'b1, 16'hffa4, 8'hf8 | 8'(c), rd);
            sosc_cpu_model_i.access(1'b0, 16'hffa4, 8'h00, rd);
            chk(rd, 8'(c));
        end
        for (int ie = 0; ie < 2; ie++) begin
            intAckEnable = ie[0];
            vecSeen = 1'b0;
            oscBefore = sosc_osc_t'(4'($urandom));
            sosc_cpu_model_i.standby(1'b0);
            repeat (3) @(negedge clk);
            wake(n);
            chk(n >= (ie ? 11 : 4) && n <= (ie ? 15 : 8), 1'b1);
            @(negedge clk);
            chk(vecSeen, ie[0]);
        end
        stop_run(1, 1'b1);
        stop_run(2, 1'b1);
        stop_run(1, 1'b0);
        // fast-osc cpu polls the status, awaiting no more than selected
        repeat (9000) @(negedge clk);
        sosc_cpu_model_i.access(1'b0, 16'hffa3, 8'h00, rd);
        chk(rd, model(1, 9000));
        mainOscStopWr = 1'b1;
        @(negedge clk);
        mainOscStopWr = 1'b0;
        sosc_cpu_model_i.access(1'b0, 16'hffa3, 8'h00, rd);
        chk(rd, 8'h00);
        sosc_cpu_model_i.standby(1'b0);
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        chk(cpuClkEnable, 1'b1);
        sosc_cpu_model_i.access(1'b0, 16'hffa4, 8'h00, rd);
        chk(rd, 8'h05);
        tally_and_finish;
    end
endmodule // sosc_standby_ctrl_test
